/* rtl/sbcs_pkg.sv */
// Package for the serial status and daisy-chain port of the system basis chip
package sbcs_pkg;

  localparam int WORD_LEN = 16;
  localparam int CH_NUM   = 8;
  localparam int SINK_CH  = 3;
  localparam int SYNC_W   = 18;

  // Configuration word field positions
  localparam int CFG_HISPEED  = 15;
  localparam int CFG_TXD_OFF  = 14;
  localparam int CFG_IHALF    = 13;
  localparam int CFG_LIN_EN   = 12;
  localparam int CFG_SLEEP    = 11;
  localparam int CFG_DIV_EN   = 10;
  localparam int CFG_DIV_SRC  = 9;
  localparam int CFG_PROG     = 8;
  localparam int CFG_ADDR_HI  = 7;
  localparam int CFG_ADDR_LO  = 5;
  localparam int CFG_SRC_EN   = 4;
  localparam int CFG_SINK     = 3;
  localparam int CFG_INT_CTL  = 2;
  localparam int CFG_SHARED   = 1;
  localparam int CFG_WD_OFF   = 0;

  // Interrupt cause codes
  localparam logic [1:0] IRQ_POWER_UP = 2'h0;
  localparam logic [1:0] IRQ_IGN_WAKE = 2'h2;
  localparam logic [1:0] IRQ_LIN_WAKE = 2'h3;

  localparam logic [15:0] CFG_RESET  = 16'h0000;
  localparam logic [4:0]  CNT_RESET  = 5'h00;
  localparam logic [4:0]  CNT_FULL   = 5'h10;
  localparam logic [4:0]  CNT_BEYOND = 5'h11;

  typedef struct packed {
    logic [3:0] mux_field;
    logic       watchdog_on_flag;
    logic       supply_low_flag;
    logic       irq_cause_hi;
    logic       irq_cause_lo;
    logic [7:0] switch_compare_result;
  } sbcs_status_t;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
  } sbcs_link_t;

endpackage

/* rtl/sbcs_spi_status.sv */
// Serial status port of the system basis chip with daisy-chain shift-through
`timescale 1ns/1ps
module sbcs_spi_status
  import sbcs_pkg::*;
#(
  parameter int CHANNELS = CH_NUM
) (
  // Clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  // Serial link pins
  input  wire logic                i_sck,
  input  wire logic                i_chip_select_low_n,
  input  wire logic                i_mosi,
  output logic                     o_miso,
  output logic                     o_miso_oe_n,
  // Analog and event sources for the status word
  input  wire logic                i_regulator_hot_flag,
  input  wire logic                i_bus_driver_hot_flag,
  input  wire logic                i_source_hot_flag,
  input  wire logic                i_ignition_input,
  input  wire logic                i_supply_low,
  input  wire logic [CHANNELS-1:0] i_switch_compare_result,
  input  wire logic                i_ignition_wake,
  input  wire logic                i_lin_wake,
  // Global configuration outputs
  output logic                     o_lin_high_speed,
  output logic                     o_txd_timeout_off,
  output logic                     o_current_half,
  output logic                     o_lin_enable,
  output logic                     o_sleep_request,
  output logic                     o_divider_out_enable,
  output logic                     o_divider_shows_switch,
  output logic [2:0]               o_divider_channel_addr,
  output logic                     o_slope_control_off,
  output logic                     o_watchdog_off,
  // Per-channel configuration outputs
  output logic [CHANNELS-1:0]      o_source_enable,
  output logic [CHANNELS-1:0]      o_source_internal_control,
  output logic [CHANNELS-1:0]      o_switch_irq_enable,
  output logic [SINK_CH-1:0]       o_sink_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;

  assign async_in = {i_sck, i_chip_select_low_n, i_mosi,
                     i_regulator_hot_flag, i_bus_driver_hot_flag,
                     i_source_hot_flag, i_ignition_input, i_supply_low,
                     i_switch_compare_result, i_ignition_wake, i_lin_wake};

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      // Idle link levels in both stages, so no false select edge follows reset
      meta_r <= {1'b0, 1'b1, {(SYNC_W-2){1'b0}}};
      sync_r <= {1'b0, 1'b1, {(SYNC_W-2){1'b0}}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  sbcs_link_t link;
  wire logic  reg_hot;
  wire logic  drv_hot;
  wire logic  src_hot;
  wire logic  ign_level;
  wire logic  supply_low;
  wire logic [CHANNELS-1:0] compare;
  wire logic  ign_wake;
  wire logic  lin_wake;

  assign link       = sync_r[SYNC_W-1 -: 3];
  assign reg_hot    = sync_r[14];
  assign drv_hot    = sync_r[13];
  assign src_hot    = sync_r[12];
  assign ign_level  = sync_r[11];
  assign supply_low = sync_r[10];
  assign compare    = sync_r[9:2];
  assign ign_wake   = sync_r[1];
  assign lin_wake   = sync_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised link

  logic sck_d_r;
  logic cs_n_d_r;
  logic ign_wake_d_r;
  logic lin_wake_d_r;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_d_r      <= 1'b0;
      cs_n_d_r     <= 1'b1;
      ign_wake_d_r <= 1'b0;
      lin_wake_d_r <= 1'b0;
    end else begin
      sck_d_r      <= link.sck;
      cs_n_d_r     <= link.cs_n;
      ign_wake_d_r <= ign_wake;
      lin_wake_d_r <= lin_wake;
    end
  end

  wire logic selected;
  wire logic cs_fall;
  wire logic cs_rise;
  wire logic sck_rise;
  wire logic sck_fall;

  assign selected = ~link.cs_n & ~cs_n_d_r;
  assign cs_fall  = ~link.cs_n & cs_n_d_r;
  assign cs_rise  = link.cs_n & ~cs_n_d_r;
  // Clock edges count only inside a frame
  assign sck_rise = selected & link.sck & ~sck_d_r;
  assign sck_fall = selected & ~link.sck & sck_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register and its decoding

  logic [WORD_LEN-1:0] cfg_r;
  logic [CHANNELS-1:0] src_en_r;
  logic [CHANNELS-1:0] int_ctl_r;
  logic [CHANNELS-1:0] irq_en_r;
  logic [SINK_CH-1:0]  sink_r;
  logic                slope_off_r;
  logic [WORD_LEN-1:0] rx_r;
  logic [4:0]          cnt_r;

  // Only a frame of exactly one word is taken as a command
  wire logic load_cmd;
  wire logic word_read;
  wire logic prog;
  wire logic [2:0] addr;

  assign load_cmd  = cs_rise & (cnt_r == CNT_FULL);
  assign word_read = cs_rise & (cnt_r >= CNT_FULL);
  assign prog      = rx_r[CFG_PROG];
  assign addr      = rx_r[CFG_ADDR_HI:CFG_ADDR_LO];

  function automatic logic ch_hit(input logic [2:0] a, input int ch);
    ch_hit = (a == ch[2:0]);
  endfunction

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r       <= CFG_RESET;
      slope_off_r <= 1'b0;
    end else if (load_cmd) begin
      cfg_r <= rx_r;
      if (!prog) begin
        slope_off_r <= rx_r[CFG_SHARED];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
      wire logic upd;
      assign upd = load_cmd & prog & ch_hit(addr, g);
      always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          src_en_r[g]  <= 1'b0;
          int_ctl_r[g] <= 1'b0;
          irq_en_r[g]  <= 1'b0;
        end else if (upd) begin
          src_en_r[g]  <= rx_r[CFG_SRC_EN];
          int_ctl_r[g] <= rx_r[CFG_INT_CTL];
          irq_en_r[g]  <= rx_r[CFG_SHARED];
        end
      end
      // Sink mode exists on the first channels only
      if (g < SINK_CH) begin : g_sink
        always_ff @(posedge i_sys_clk or posedge i_rst) begin
          if (i_rst) begin
            sink_r[g] <= 1'b0;
          end else if (upd) begin
            sink_r[g] <= rx_r[CFG_SINK];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt cause field

  logic [1:0] cause_r;
  logic [1:0] cause_nxt;

  wire logic ign_evt;
  wire logic lin_evt;

  assign ign_evt = ign_wake & ~ign_wake_d_r;
  assign lin_evt = lin_wake & ~lin_wake_d_r;

  // A wake-up in the clearing cycle survives the clear
  always_comb begin
    cause_nxt = cause_r;
    if (word_read) begin
      cause_nxt = IRQ_POWER_UP;
    end
    if (lin_evt) begin
      cause_nxt = IRQ_LIN_WAKE;
    end else if (ign_evt) begin
      cause_nxt = IRQ_IGN_WAKE;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cause_r <= IRQ_POWER_UP;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word assembly

  sbcs_status_t status;
  wire logic    div_prev;

  // Uses the configuration of the previous command
  assign div_prev = cfg_r[CFG_DIV_EN];

  assign status.mux_field = div_prev ?
    {~cfg_r[CFG_DIV_SRC], cfg_r[CFG_ADDR_HI:CFG_ADDR_LO]} :
    {reg_hot, drv_hot, src_hot, ign_level};
  assign status.watchdog_on_flag      = ~cfg_r[CFG_WD_OFF];
  assign status.supply_low_flag       = supply_low;
  assign status.irq_cause_hi          = cause_r[1];
  assign status.irq_cause_lo          = cause_r[0];
  assign status.switch_compare_result = compare;

  ////////////////////////////////////////////////////////////////////////////
  // Shift path, clock counter and output pin

  logic [WORD_LEN-1:0] sh_r;
  logic                mosi_bit_r;
  logic                miso_r;
  logic                miso_oe_n_r;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= CNT_RESET;
      rx_r  <= '0;
    end else if (cs_fall) begin
      cnt_r <= CNT_RESET;
    end else if (sck_rise) begin
      rx_r <= {rx_r[WORD_LEN-2:0], link.mosi};
      if (cnt_r != CNT_BEYOND) begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  // Received bits follow the status word, one word late
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_r       <= '0;
      mosi_bit_r <= 1'b0;
    end else if (cs_fall) begin
      sh_r <= status;
    end else if (sck_rise) begin
      mosi_bit_r <= link.mosi;
    end else if (sck_fall) begin
      sh_r <= {sh_r[WORD_LEN-2:0], mosi_bit_r};
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      miso_r      <= 1'b0;
      miso_oe_n_r <= 1'b1;
    end else if (cs_fall) begin
      miso_r      <= status[WORD_LEN-1];
      miso_oe_n_r <= 1'b0;
    end else if (link.cs_n) begin
      miso_oe_n_r <= 1'b1;
    end else if (sck_fall) begin
      miso_r <= sh_r[WORD_LEN-2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_miso                    = miso_r;
  assign o_miso_oe_n               = miso_oe_n_r;
  assign o_lin_high_speed          = cfg_r[CFG_HISPEED];
  assign o_txd_timeout_off         = cfg_r[CFG_TXD_OFF];
  assign o_current_half            = cfg_r[CFG_IHALF];
  assign o_lin_enable              = cfg_r[CFG_LIN_EN];
  assign o_sleep_request           = cfg_r[CFG_SLEEP];
  assign o_divider_out_enable      = cfg_r[CFG_DIV_EN];
  assign o_divider_shows_switch    = cfg_r[CFG_DIV_SRC];
  assign o_divider_channel_addr    = cfg_r[CFG_ADDR_HI:CFG_ADDR_LO];
  assign o_slope_control_off       = slope_off_r;
  assign o_watchdog_off            = cfg_r[CFG_WD_OFF];
  assign o_source_enable           = src_en_r;
  assign o_source_internal_control = int_ctl_r;
  assign o_switch_irq_enable       = irq_en_r;
  assign o_sink_select             = sink_r;

endmodule

/* tb/sbcs_spi_props.sv */
// Checker for the serial status port
`timescale 1ns/1ps
module sbcs_spi_props
  import sbcs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_chip_select_low_n,
  input wire logic i_regulator_hot_flag,
  input wire logic o_miso,
  input wire logic o_miso_oe_n,
  input wire logic o_divider_out_enable,
  input wire logic o_divider_shows_switch,
  input wire logic o_lin_enable
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wire logic cs_n = i_chip_select_low_n;

  a_oe_idle: assert property (cs_n [*5] |-> o_miso_oe_n)
    else $error("miso driven while deselected");
  a_oe_active: assert property ($fell(cs_n) ##1 !cs_n [*5] |-> !o_miso_oe_n)
    else $error("miso not driven in frame");
  a_oe_release: assert property ($rose(cs_n) |-> ##[2:5] o_miso_oe_n)
    else $error("miso not released after frame");
  a_miso_hold: assert property (i_sck [*5] |-> $stable(o_miso))
    else $error("miso moved while clock high");
  a_cfg_frame: assert property (!cs_n [*5] |-> $stable(o_lin_enable))
    else $error("config changed inside frame");
  a_cfg_idle: assert property (cs_n [*7] |-> $stable(o_divider_out_enable))
    else $error("config changed while deselected");
  // Inputs are held still around frames, so the live flag is the captured one
  a_first_bit: assert property ($fell(cs_n) |-> ##5 o_miso == (o_divider_out_enable ?
    !o_divider_shows_switch : i_regulator_hot_flag)) else $error("wrong first status bit");
  a_cfg_cause: assert property ($changed(o_lin_enable) |-> cs_n && $past(cs_n, 2))
    else $error("config changed without frame end");

  c_frame: cover property ($fell(cs_n));
  c_load: cover property ($rose(o_lin_enable));
  c_route: cover property ($rose(o_divider_out_enable));
endmodule

bind sbcs_spi_status sbcs_spi_props u_props (.i_sys_clk, .i_rst, .i_sck,
  .i_chip_select_low_n, .i_regulator_hot_flag, .o_miso, .o_miso_oe_n,
  .o_divider_out_enable, .o_divider_shows_switch, .o_lin_enable);

/* tb/sbcs_master.sv */
// Host master model driving framed serial transfers
`timescale 1ns/1ps
module sbcs_master (
  output logic     o_sck,
  output logic     o_cs_n,
  output logic     o_mosi,
  input wire logic i_miso
);
  localparam realtime HALF = 62.5;

  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // Clock stands low between frames; sel low leaves the device deselected
  task automatic xfer(input int n, input logic sel, input logic [31:0] tx,
                      output logic [31:0] rx);
    rx = '0;
    o_cs_n <= !sel;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi <= tx[i];
      #HALF o_sck <= 1'b1;
      rx = {rx[30:0], i_miso};
      #HALF o_sck <= 1'b0;
    end
    #100 o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi;
    #200;
  endtask
endmodule

/* tb/sbcs_spi_status_tb_top.sv */
// Testbench for the serial status port
`timescale 1ns/1ps
module sbcs_spi_status_tb_top import sbcs_pkg::*;;
  logic        i_sys_clk, i_rst, i_sck, i_chip_select_low_n, i_mosi, o_miso, o_miso_oe_n;
  logic        i_regulator_hot_flag, i_bus_driver_hot_flag, i_source_hot_flag;
  logic        i_ignition_input, i_supply_low, i_ignition_wake, i_lin_wake;
  logic        o_lin_enable, o_divider_out_enable, o_divider_shows_switch, o_watchdog_off;
  logic [7:0]  i_switch_compare_result, o_source_enable, o_source_internal_control;
  logic        o_lin_high_speed, o_txd_timeout_off, o_current_half, o_sleep_request;
  logic        o_slope_control_off;
  logic [7:0]  o_switch_irq_enable;
  logic [2:0]  o_divider_channel_addr, o_sink_select;
  logic [15:0] pcmd;
  logic [31:0] rx;
  int          fails, n_compared;
  wire         miso_w = o_miso_oe_n ? 1'bz : o_miso;

  sbcs_spi_status dut (.i_sys_clk, .i_rst, .i_sck, .i_chip_select_low_n, .i_mosi, .o_miso,
    .o_miso_oe_n, .i_regulator_hot_flag, .i_bus_driver_hot_flag, .i_source_hot_flag,
    .i_ignition_input, .i_supply_low, .i_switch_compare_result, .i_ignition_wake,
    .i_lin_wake, .o_lin_high_speed, .o_txd_timeout_off, .o_current_half,
    .o_lin_enable, .o_sleep_request, .o_divider_out_enable, .o_divider_shows_switch,
    .o_divider_channel_addr, .o_slope_control_off, .o_watchdog_off, .o_source_enable,
    .o_source_internal_control, .o_switch_irq_enable, .o_sink_select);
  sbcs_master m (.o_sck(i_sck), .o_cs_n(i_chip_select_low_n), .o_mosi(i_mosi),
    .i_miso(miso_w));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic results;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Status word built from the last loaded command and the live inputs
  function automatic logic [15:0] st(input logic [1:0] cause);
    return {pcmd[10] ? {~pcmd[9], pcmd[7:5]} : {i_regulator_hot_flag,
      i_bus_driver_hot_flag, i_source_hot_flag, i_ignition_input}, ~pcmd[0],
      i_supply_low, cause, i_switch_compare_result};
  endfunction

  // Configuration outputs placed at their command bit positions
  function automatic logic [15:0] cfgw();
    return {o_lin_high_speed, o_txd_timeout_off, o_current_half, o_lin_enable, o_sleep_request,
      o_divider_out_enable, o_divider_shows_switch, 1'h0, o_divider_channel_addr, 3'h0,
      o_slope_control_off, o_watchdog_off};
  endfunction

  task automatic frame(input logic [15:0] cmd, input logic [1:0] cause);
    m.xfer(16, 1'b1, {16'h0000, cmd}, rx);
    chk("status", st(cause), rx[15:0]);
    pcmd = cmd;
  endtask

  initial begin
    #200000;
    fails++;
    results();
  end

  initial begin
    fails = 0;
    n_compared = 0;
    pcmd = CFG_RESET;
    i_rst = 1'b1;
    {i_regulator_hot_flag, i_bus_driver_hot_flag, i_source_hot_flag} = 3'h5;
    i_ignition_input = 1'b1;
    i_supply_low = 1'b1;
    i_switch_compare_result = 8'hC5;
    i_ignition_wake = 1'b0;
    i_lin_wake = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    frame(16'h1401, IRQ_POWER_UP);
    chk("cfg", 16'h1401, cfgw());
    frame(16'h06A0, IRQ_POWER_UP);
    chk("cfg_route", 16'h06A0, cfgw());
    frame(16'h0000, IRQ_POWER_UP);
    i_ignition_wake <= 1'b1;
    i_supply_low <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    frame(16'h0000, IRQ_IGN_WAKE);
    i_lin_wake <= 1'b1;
    {i_regulator_hot_flag, i_bus_driver_hot_flag, i_source_hot_flag} <= 3'h2;
    i_ignition_input <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    frame(16'h0000, IRQ_LIN_WAKE);
    frame(16'h0000, IRQ_POWER_UP);
    frame(16'h017C, IRQ_POWER_UP);
    frame(16'h012A, IRQ_POWER_UP);
    chk("src_en", 16'h0008, {8'h00, o_source_enable});
    chk("int_ctl", 16'h0008, {8'h00, o_source_internal_control});
    chk("sink", 16'h0002, {13'h0000, o_sink_select});
    chk("irq_en", 16'h0002, {8'h00, o_switch_irq_enable});
    m.xfer(32, 1'b1, 32'h1401_5AC3, rx);
    chk("chain_st", st(IRQ_POWER_UP), rx[31:16]);
    chk("chain_dat", 16'h1401, rx[15:0]);
    chk("chain_cfg", 16'h0000, {15'h0000, o_lin_enable});
    m.xfer(8, 1'b1, 32'h0000_00FF, rx);
    m.xfer(16, 1'b0, 32'h0000_1401, rx);
    chk("ignored", 16'h0000, {15'h0000, o_lin_enable});
    frame(16'h0000, IRQ_POWER_UP);
    frame(16'hFA03, IRQ_POWER_UP);
    chk("cfg_all", 16'hFA03, cfgw());
    results();
  end
endmodule
